// >>> pkg/spcr_pkg.sv
// Package for the port policy and boot cluster configuration register bank
package spcr_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_PORT_POLICY = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_BOOT_INFO   = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_RESTORE_KEY = 4'h8;

  localparam logic [DATA_W-1:0] RESTORE_KEY = 32'ha50ff0fa;

  // Port policy field positions
  localparam int unsigned PP_P1_WR_AP   = 22;
  localparam int unsigned PP_P1_RD_AP   = 21;
  localparam int unsigned PP_P0_WR_AP   = 20;
  localparam int unsigned PP_P0_RD_AP   = 19;
  localparam int unsigned PP_M0_WAKE    = 18;
  localparam int unsigned PP_S1_WAKE    = 17;
  localparam int unsigned PP_S0_WAKE    = 16;
  localparam int unsigned PP_P4_WR_RGN  = 12;
  localparam int unsigned PP_P4_RD_RGN  = 8;
  localparam int unsigned PP_P3_WR_RGN  = 4;
  localparam int unsigned PP_P3_RD_RGN  = 0;

  // Boot info field positions
  localparam int unsigned BI_BOOT_GROUP = 28;
  localparam int unsigned BI_BOOT_CORE  = 24;
  localparam int unsigned BI_SMALL_CNT  = 20;
  localparam int unsigned BI_LARGE_CNT  = 16;
  localparam int unsigned BI_ACTIVE     = 0;

  // Writable bit masks; all other bits are reserved
  localparam logic [DATA_W-1:0] PP_MASK = 32'h007fffff;
  localparam logic [DATA_W-1:0] BI_MASK = 32'h13fff803;

  // Values after reset
  localparam logic [DATA_W-1:0] PP_RESET = 32'h00070000;
  localparam logic [DATA_W-1:0] BI_RESET = 32'h0032f003;

  typedef struct packed {
    logic       p1_write_autoprecharge;
    logic       p1_read_autoprecharge;
    logic       p0_write_autoprecharge;
    logic       p0_read_autoprecharge;
    logic       master0_gate_wake;
    logic       slave1_gate_wake;
    logic       slave0_gate_wake;
    logic [3:0] port4_write_region_id;
    logic [3:0] port4_read_region_id;
    logic [3:0] port3_write_region_id;
    logic [3:0] port3_read_region_id;
  } spcr_port_s;

  typedef struct packed {
    logic       boot_small_group;
    logic [1:0] boot_core;
    logic [3:0] small_group_core_count;
    logic [3:0] large_group_core_count;
    logic [1:0] active_groups;
  } spcr_boot_s;

endpackage

// >>> logic/spcr_cfg_word.sv
// One configuration word with reserved-bit masking and restore to default
`timescale 1ns/1ps
`default_nettype none
module spcr_cfg_word #(
  parameter logic [31:0] RESET_VAL = 32'h00000000,
  parameter logic [31:0] MASK      = 32'hffffffff
) (
  input  wire logic        clock,    // System clock
  input  wire logic        rst_n,    // Synchronised reset, active low
  input  wire logic        wr_en,    // Write this word
  input  wire logic        restore,  // Return to default
  input  wire logic [31:0] wr_data,  // Write data
  output logic      [31:0] value     // Stored word
);

  logic [31:0] word_reg;
  logic [31:0] word_next;

  // Restore takes priority over a write in the same cycle
  assign word_next = restore ? RESET_VAL : (wr_data & MASK);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      word_reg <= RESET_VAL;
    end else if (wr_en || restore) begin
      word_reg <= word_next;
    end
  end

  assign value = word_reg;

endmodule // spcr_cfg_word
`default_nettype wire

// >>> logic/spcr_regs.sv
// Port policy and boot cluster configuration register bank
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module spcr_regs (
  input  wire logic                     clock,     // 20 MHz system clock
  input  wire logic                     rst_n,     // Asynchronous reset, active low
  input  wire logic [3:0]               addr,      // Register byte address
  input  wire logic [31:0]              wdata,     // Write data
  input  wire logic                     wr,        // Write strobe
  input  wire logic                     rd,        // Read strobe
  output logic      [31:0]              rdata,     // Read data, cycle after rd
  output spcr_pkg::spcr_port_s          port_cfg,  // Memory and interconnect port settings
  output spcr_pkg::spcr_boot_s          boot_cfg   // Boot cluster settings
);

  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  wire sel_pp   = (addr == spcr_pkg::OFF_PORT_POLICY);
  wire sel_bi   = (addr == spcr_pkg::OFF_BOOT_INFO);
  wire sel_key  = (addr == spcr_pkg::OFF_RESTORE_KEY);
  // Only the exact key restores; any other value is dropped
  wire restore  = wr && sel_key && (wdata == spcr_pkg::RESTORE_KEY);

  wire [31:0] pp_val;
  wire [31:0] bi_val;

  // Port policy bits 15..11 feed the port4 region ids; boot info hint bits 15..11 are plain storage and steer nothing
  spcr_cfg_word #(
    .RESET_VAL (spcr_pkg::PP_RESET),
    .MASK      (spcr_pkg::PP_MASK)
  ) u_port_policy (
    .clock   (clock),
    .rst_n   (rst_sync_reg),
    .wr_en   (wr && sel_pp),
    .restore (restore),
    .wr_data (wdata),
    .value   (pp_val)
  );

  spcr_cfg_word #(
    .RESET_VAL (spcr_pkg::BI_RESET),
    .MASK      (spcr_pkg::BI_MASK)
  ) u_boot_info (
    .clock   (clock),
    .rst_n   (rst_sync_reg),
    .wr_en   (wr && sel_bi),
    .restore (restore),
    .wr_data (wdata),
    .value   (bi_val)
  );

  // Key register is write-only and reads as zero, as do unmapped addresses
  wire [31:0] rd_mux = sel_pp ? pp_val : (sel_bi ? bi_val : 32'h00000000);

  spcr_pkg::spcr_port_s port_next;
  spcr_pkg::spcr_boot_s boot_next;

  // Output defaults are cut from the register defaults so the two never drift apart
  localparam spcr_pkg::spcr_port_s PORT_RST = spcr_pkg::PP_RESET[22:0];
  localparam spcr_pkg::spcr_boot_s BOOT_RST = {spcr_pkg::BI_RESET[28], spcr_pkg::BI_RESET[25:16],
                                               spcr_pkg::BI_RESET[1:0]};

  assign port_next.p1_write_autoprecharge = pp_val[spcr_pkg::PP_P1_WR_AP];
  assign port_next.p1_read_autoprecharge  = pp_val[spcr_pkg::PP_P1_RD_AP];
  assign port_next.p0_write_autoprecharge = pp_val[spcr_pkg::PP_P0_WR_AP];
  assign port_next.p0_read_autoprecharge  = pp_val[spcr_pkg::PP_P0_RD_AP];
  assign port_next.master0_gate_wake      = pp_val[spcr_pkg::PP_M0_WAKE];
  assign port_next.slave1_gate_wake       = pp_val[spcr_pkg::PP_S1_WAKE];
  assign port_next.slave0_gate_wake       = pp_val[spcr_pkg::PP_S0_WAKE];
  assign port_next.port4_write_region_id  = pp_val[spcr_pkg::PP_P4_WR_RGN +: 4];
  assign port_next.port4_read_region_id   = pp_val[spcr_pkg::PP_P4_RD_RGN +: 4];
  assign port_next.port3_write_region_id  = pp_val[spcr_pkg::PP_P3_WR_RGN +: 4];
  assign port_next.port3_read_region_id   = pp_val[spcr_pkg::PP_P3_RD_RGN +: 4];

  assign boot_next.boot_small_group       = bi_val[spcr_pkg::BI_BOOT_GROUP];
  assign boot_next.boot_core              = bi_val[spcr_pkg::BI_BOOT_CORE +: 2];
  assign boot_next.small_group_core_count = bi_val[spcr_pkg::BI_SMALL_CNT +: 4];
  assign boot_next.large_group_core_count = bi_val[spcr_pkg::BI_LARGE_CNT +: 4];
  assign boot_next.active_groups          = bi_val[spcr_pkg::BI_ACTIVE +: 2];

  // Outputs are registered so downstream ports see clean levels
  always_ff @(posedge clock or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      rdata    <= 32'h00000000;
      port_cfg <= PORT_RST;
      boot_cfg <= BOOT_RST;
    end else begin
      rdata    <= rd ? rd_mux : 32'h00000000;
      port_cfg <= port_next;
      boot_cfg <= boot_next;
    end
  end

  // Assertions
  a_key_restores_port: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    restore |-> ##1 pp_val == spcr_pkg::PP_RESET) else $error("key did not restore port word");
  a_key_restores_boot: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    restore |-> ##1 bi_val == spcr_pkg::BI_RESET) else $error("key did not restore boot word");
  a_bad_key_holds: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    (wr && sel_key && !restore) |-> ##1 ($stable(pp_val) && $stable(bi_val)))
    else $error("wrong key changed a register");
  a_reserved_read_zero: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    rd |-> ##1 ((rdata & ~(spcr_pkg::PP_MASK | spcr_pkg::BI_MASK)) == 32'h00000000))
    else $error("reserved bits read nonzero");
  a_pp_read_back: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    (rd && sel_pp) |=> rdata == $past(pp_val)) else $error("port word read mismatch");
  a_wake_follows: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    (wr && sel_pp) |-> ##2 port_cfg.master0_gate_wake == $past(wdata[18], 2))
    else $error("gate wake output mismatch");
  a_region_follows: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    (wr && sel_pp) |-> ##2 (port_cfg.port4_write_region_id == $past(wdata[15:12], 2) &&
    port_cfg.port3_read_region_id == $past(wdata[3:0], 2))) else $error("region id mismatch");
  a_boot_follows: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    (wr && sel_bi) |-> ##2 (boot_cfg.boot_core == $past(wdata[25:24], 2) &&
    boot_cfg.active_groups == $past(wdata[1:0], 2))) else $error("boot field mismatch");
  a_key_restores_outputs: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    restore |-> ##2 (port_cfg == PORT_RST && boot_cfg == BOOT_RST))
    else $error("key did not restore outputs");
  a_rdata_idle_zero: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    !rd |=> rdata == 32'h00000000) else $error("read data not zero outside a read");
  a_boot_group_follows: assert property (@(posedge clock) disable iff (!rst_sync_reg)
    (wr && sel_bi) |-> ##2 (boot_cfg.boot_small_group == $past(wdata[28], 2) &&
    boot_cfg.small_group_core_count == $past(wdata[23:20], 2) &&
    boot_cfg.large_group_core_count == $past(wdata[19:16], 2))) else $error("boot group mismatch");

endmodule // spcr_regs
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the port policy and boot cluster register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                 clock        = 1'b0;
  logic                 rst_n        = 1'b0;
  logic [3:0]           addr         = 4'h0;
  logic [31:0]          wdata        = 32'h00000000;
  logic                 wr           = 1'b0;
  logic                 rd           = 1'b0;
  logic [31:0]          rdata;
  spcr_pkg::spcr_port_s port_cfg;
  spcr_pkg::spcr_boot_s boot_cfg;
  logic [31:0]          pp_exp;
  logic [31:0]          bi_exp;
  logic [31:0]          seed;
  logic [31:0]          wval;
  int                   num_errors   = 0;
  int                   total_checks = 0;

  always #25 clock = ~clock;

  spcr_regs u_spcr_regs (
    .clock    (clock),
    .rst_n    (rst_n),
    .addr     (addr),
    .wdata    (wdata),
    .wr       (wr),
    .rd       (rd),
    .rdata    (rdata),
    .port_cfg (port_cfg),
    .boot_cfg (boot_cfg)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Fields that leave the block; hint bits 15..11 stay inside
  function automatic logic [12:0] boot_view(input logic [31:0] w);
    return {w[28], w[25:16], w[1:0]};
  endfunction

  task automatic conclude();
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1;
    chk($sformatf("rdata at %h", a), exp, rdata);
  endtask

  task automatic check_all();
    rd_chk(4'h0, pp_exp);
    rd_chk(4'h4, bi_exp);
    chk("port_cfg", {9'h000, pp_exp[22:0]}, {9'h000, port_cfg});
    chk("boot_cfg", {19'h00000, boot_view(bi_exp)}, {19'h00000, boot_cfg});
  endtask

  initial begin
    #2000000;
    num_errors++;
    conclude();
  end

  initial begin
    seed   = 32'hbaf7bd4a;
    pp_exp = 32'h00070000;
    bi_exp = 32'h0032f003;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    check_all();
    rd_chk(4'h8, 32'h00000000);
    rd_chk(4'hc, 32'h00000000);
    for (int i = 0; i < 24; i++) begin
      // Corner words go beside the sequence so an all-zero word never seeds it
      seed = lfsr(seed);
      wval = (i == 0) ? 32'hffffffff : ((i == 1) ? 32'h00000000 : seed);
      wr_reg(4'h0, wval);
      pp_exp = wval & 32'h007fffff;
      seed = lfsr(seed);
      wval = (i == 0) ? 32'hffffffff : ((i == 1) ? 32'h00000000 : seed);
      wr_reg(4'h4, wval);
      bi_exp = wval & 32'h13fff803;
      check_all();
    end
    wr_reg(4'hc, 32'hffffffff);
    wr_reg(4'h8, 32'h000a50f5);
    wr_reg(4'h8, 32'ha50ff0fb);
    check_all();
    // Software normally avoids this write; here it is the point of the test
    wr_reg(4'h8, 32'ha50ff0fa);
    pp_exp = 32'h00070000;
    bi_exp = 32'h0032f003;
    check_all();
    wr_reg(4'h0, 32'h00512345);
    pp_exp = 32'h00512345;
    check_all();
    @(posedge clock);
    rst_n <= 1'b0;
    @(posedge clock);
    #1;
    chk("port_cfg in reset", 32'h00070000, {9'h000, port_cfg});
    chk("boot_cfg in reset", {19'h00000, boot_view(32'h0032f003)}, {19'h00000, boot_cfg});
    rst_n <= 1'b1;
    pp_exp = 32'h00070000;
    repeat (3) @(posedge clock);
    check_all();
    conclude();
  end
endmodule // tb_top
`default_nettype wire
